// *** rsfc_pkg.sv ***
//==========================================================
// How it works
// [RULE_01] Five-bit stack pointer, values 0 to 31
// [RULE_02] Push increments first; pop reads then decrements
// [RULE_03] hresetn and stack-fault reset force pointer to zero; power-on (por_n) only clears the flags
// [RULE_04] Software reads and writes pointer directly
// [RULE_05] Full flag after 31 unpopped pushes
// [RULE_06] Overflow reset on: store PC+2, reset, pointer zero
// [RULE_07] Overflow reset off: pointer holds 31, entry kept
// [RULE_08] Empty pop sets underflow; an empty return also loads zero PC
// [RULE_09] Enable chooses flag plus reset or flag only
// [RULE_10] Flags stay until software clear or power-on; hresetn also clears them here
// [RULE_11] Bits 7,6 flags, bit 5 zero, 4:0 pointer
// [RULE_12] Push instruction stores current PC on new top
// [RULE_13] Pop instruction only decrements pointer
// [RULE_14] Hidden shadow loaded on every interrupt vectoring
// [RULE_15] Fast call saves shadow; fast return restores it
// [RULE_16] Software keeps computed jump offsets even
// [RULE_17] Clock divided by four into quadrature phases
// [RULE_18] PC steps in first phase; word latched fourth
// [RULE_19] Operand read second phase, write fourth phase
// [RULE_20] Branches take two cycles, prefetch flushed
// [RULE_21] Table read returns one byte per pointer address
// [RULE_22] Top registers expose entry at current pointer
// [RULE_23] Storage 31 by 21 bits, none at zero
// [RULE_24] Low PC write loads high and upper latches
// [RULE_25] Writing one to a flag does nothing
//==========================================================
package rsfc_pkg;

  localparam int          PC_W            = 21;
  localparam int          SP_W            = 5;
  localparam int          STACK_DEPTH     = 31;
  localparam logic [4:0]  SP_MAX          = 5'h1F;
  localparam logic [11:0] ADDR_RETURN_STACK_POINTER     = 12'hFFC;
  localparam logic [11:0] ADDR_TOP_LOW    = 12'hFFD;
  localparam logic [11:0] ADDR_TOP_HIGH   = 12'hFFE;
  localparam logic [11:0] ADDR_TOP_UPPER  = 12'hFFF;
  localparam logic [11:0] ADDR_PC_LOW     = 12'hFF9;
  localparam logic [11:0] ADDR_PC_HLATCH  = 12'hFFA;
  localparam logic [11:0] ADDR_PC_ULATCH  = 12'hFFB;
  localparam logic [11:0] ADDR_TBL_PTR    = 12'hFF6;
  localparam logic [11:0] ADDR_TBL_LATCH  = 12'hFF5;
  localparam logic [11:0] ADDR_CTRL       = 12'hFF0;
  localparam int          FULL_BIT        = 7;
  localparam int          UNF_BIT         = 6;
  localparam logic [7:0]  RETURN_STACK_POINTER_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_RESET      = 8'h01;
  localparam logic [1:0]  Q_LAST          = 2'h3;

  typedef enum logic [1:0] {
    RSFC_Q1 = 2'b00,
    RSFC_Q2 = 2'b01,
    RSFC_Q3 = 2'b10,
    RSFC_Q4 = 2'b11
  } rsfc_phase_t;

  typedef enum logic [3:0] {
    RSFC_OP_NOP     = 4'h0,
    RSFC_OP_CALL    = 4'h1,
    RSFC_OP_RETURN  = 4'h2,
    RSFC_OP_INTERRUPT_RETURN  = 4'h3,
    RSFC_OP_PUSH    = 4'h4,
    RSFC_OP_POP     = 4'h5,
    RSFC_OP_GOTO    = 4'h6,
    RSFC_OP_TBLRD   = 4'h7,
    RSFC_OP_INTVEC  = 4'h8
  } rsfc_op_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working_register;
    logic [7:0] bank_select_register;
  } rsfc_ctx_t;

  typedef struct packed {
    rsfc_op_t      op;
    logic          fast;
    logic [20:0]   target;
  } rsfc_cmd_t;

endpackage : rsfc_pkg

// *** rsfc_qclock.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsfc_qclock
  import rsfc_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        sync_rst,
  // Phases
  output logic [1:0]       phase,
  output logic             q1,
  output logic             q2,
  output logic             q4
);
  logic [1:0] phase_reg;

  //==========================================================
  // Divide by four
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= 2'h0;
    end else if (sync_rst) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;  // [RULE_17]
    end
  end

  assign phase = phase_reg;
  assign q1    = (phase_reg == RSFC_Q1);
  assign q2    = (phase_reg == RSFC_Q2);
  assign q4    = (phase_reg == Q_LAST);
endmodule : rsfc_qclock
`default_nettype wire

// *** rsfc_stack_ram.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsfc_stack_ram
  import rsfc_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = PC_W
) (
  // Clock
  input  wire logic             hclk,
  // Write port
  input  wire logic             we,
  input  wire logic [4:0]       waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // Read port
  input  wire logic [4:0]       raddr,
  output logic [WIDTH-1:0]      rdata
);
  // Slot 0 has no storage; index is pointer minus one
  logic [WIDTH-1:0] mem [0:DEPTH-1];  // [RULE_23]

  always_ff @(posedge hclk) begin
    if (we && waddr != 5'h00) begin
      mem[waddr - 5'h01] <= wdata;
    end
  end

  assign rdata = (raddr == 5'h00) ? '0 : mem[raddr - 5'h01];  // [RULE_22]
endmodule : rsfc_stack_ram
`default_nettype wire

// *** rsfc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsfc_top
  import rsfc_pkg::*;
(
  // Clock and resets
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        por_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Decoder command and context
  input  wire rsfc_cmd_t   cmd,
  input  wire logic        cmd_valid,
  input  wire rsfc_ctx_t   ctx_live,
  // Program memory
  output logic [20:0]      fetch_addr,
  input  wire logic [15:0] fetch_word,
  output logic [20:0]      prog_byte_addr,
  input  wire logic [7:0]  prog_byte,
  // Core outputs
  output logic [15:0]      instruction_register,
  output logic [20:0]      program_counter,
  output logic             flush,
  output logic             cmd_ready,
  output logic             ctx_restore,
  output rsfc_ctx_t        ctx_shadow,
  output logic             operand_read,
  output logic             dest_write,
  output logic             stack_reset_req
);

  //==========================================================
  // State
  logic [4:0]  stack_level_reg;
  logic        stack_full_flag_reg;
  logic        stack_underflow_flag_reg;
  logic        stack_overflow_reset_enable_reg;
  logic [20:0] pc_reg;
  logic [7:0]  pc_hlatch_reg;
  logic [4:0]  pc_ulatch_reg;
  logic [20:0] table_byte_pointer_reg;
  logic [7:0]  table_read_latch_reg;
  logic [15:0] ir_reg;
  logic        flush_reg;
  logic        srst_reg;
  rsfc_ctx_t   shadow_reg;
  logic        restore_reg;
  logic        por_meta_reg;
  logic        por_sync_reg;

  logic        q1;
  logic        q2;
  logic        q4;
  logic [20:0] tos;
  logic        ram_we;
  logic [4:0]  ram_waddr;
  logic [20:0] ram_wdata;

  //==========================================================
  // Power-on input synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_meta_reg <= 1'b0;
      por_sync_reg <= 1'b0;
    end else begin
      por_meta_reg <= 1'b1 & por_n;
      por_sync_reg <= por_meta_reg;
    end
  end

  logic por_active;
  assign por_active = !por_sync_reg;

  //==========================================================
  // Phase clocking
  rsfc_qclock u_qclock (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .sync_rst (srst_reg),
    .phase    (),
    .q1       (q1),
    .q2       (q2),
    .q4       (q4)
  );

  //==========================================================
  // AHB-Lite address phase capture
  logic        ahb_wr_reg;
  logic        ahb_rd_reg;
  logic [11:0] ahb_addr_reg;
  logic        ahb_go;

  assign ahb_go    = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr_reg   <= 1'b0;
      ahb_rd_reg   <= 1'b0;
      ahb_addr_reg <= 12'h000;
    end else begin
      ahb_wr_reg   <= ahb_go && hwrite;
      ahb_rd_reg   <= ahb_go && !hwrite;
      ahb_addr_reg <= haddr[13:2];
    end
  end

  function automatic logic hit(input logic [11:0] idx);
    hit = ahb_wr_reg && (ahb_addr_reg == idx);
  endfunction : hit

  logic [7:0] wb;
  assign wb = hwdata[7:0];

  //==========================================================
  // Command decode; one command per instruction cycle
  logic exec;
  logic is_push;
  logic is_pop;
  logic ptr_push;
  logic ptr_pop;
  logic empty_pop;
  logic full_push;

  assign cmd_ready = q4;
  assign exec      = cmd_valid && q4 && !flush_reg;
  assign is_push   = exec && (cmd.op == RSFC_OP_CALL || cmd.op == RSFC_OP_PUSH
                              || cmd.op == RSFC_OP_INTVEC);
  assign is_pop    = exec && (cmd.op == RSFC_OP_RETURN || cmd.op == RSFC_OP_INTERRUPT_RETURN
                              || cmd.op == RSFC_OP_POP);
  assign empty_pop = is_pop && (stack_level_reg == 5'h00);
  assign full_push = is_push && (stack_level_reg >= SP_MAX - 5'h01);
  assign ptr_push  = is_push && (stack_level_reg != SP_MAX);
  assign ptr_pop   = is_pop && !empty_pop;

  // Return address already points past the call
  assign ram_waddr = ptr_push ? stack_level_reg + 5'h01 : stack_level_reg;  // [RULE_02]
  // Bus hits read module state, so only a process follows them
  always_comb begin
    ram_we    = ptr_push || hit(ADDR_TOP_LOW) || hit(ADDR_TOP_HIGH)
                || hit(ADDR_TOP_UPPER);
    ram_wdata = tos;
    if (ptr_push) begin
      ram_wdata = pc_reg;  // [RULE_12] [RULE_06]
    end else if (hit(ADDR_TOP_LOW)) begin
      ram_wdata = {tos[20:8], wb};  // [RULE_22]
    end else if (hit(ADDR_TOP_HIGH)) begin
      ram_wdata = {tos[20:16], wb, tos[7:0]};
    end else if (hit(ADDR_TOP_UPPER)) begin
      ram_wdata = {wb[4:0], tos[15:0]};
    end
  end

  rsfc_stack_ram u_stack (
    .hclk  (hclk),
    .we    (ram_we),
    .waddr (ram_waddr),
    .wdata (ram_wdata),
    .raddr (stack_level_reg),
    .rdata (tos)
  );

  //==========================================================
  // Stack pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stack_level_reg <= 5'h00;  // [RULE_03]
    end else if (srst_reg) begin
      stack_level_reg <= 5'h00;  // [RULE_03] [RULE_06]
    end else if (ptr_push) begin
      stack_level_reg <= stack_level_reg + 5'h01;  // [RULE_01] [RULE_07]
    end else if (ptr_pop) begin
      stack_level_reg <= stack_level_reg - 5'h01;  // [RULE_13] [RULE_02]
    end else if (hit(ADDR_RETURN_STACK_POINTER)) begin
      stack_level_reg <= wb[4:0];  // [RULE_04]
    end
  end

  //==========================================================
  // Sticky flags; POR clear wins over set, set beats a software write of zero, which otherwise clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stack_full_flag_reg      <= 1'b0;
      stack_underflow_flag_reg <= 1'b0;
    end else if (por_active) begin
      stack_full_flag_reg      <= 1'b0;  // [RULE_10]
      stack_underflow_flag_reg <= 1'b0;
    end else begin
      if (full_push) begin
        stack_full_flag_reg <= 1'b1;  // [RULE_05]
      end else if (hit(ADDR_RETURN_STACK_POINTER) && !wb[FULL_BIT]) begin
        stack_full_flag_reg <= 1'b0;  // [RULE_25]
      end
      if (empty_pop) begin
        stack_underflow_flag_reg <= 1'b1;  // [RULE_08]
      end else if (hit(ADDR_RETURN_STACK_POINTER) && !wb[UNF_BIT]) begin
        stack_underflow_flag_reg <= 1'b0;  // [RULE_25]
      end
    end
  end

  //==========================================================
  // Stack-fault device reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      srst_reg <= 1'b0;
    end else begin
      srst_reg <= stack_overflow_reset_enable_reg && (full_push || empty_pop);  // [RULE_09]
    end
  end
  assign stack_reset_req = srst_reg;

  //==========================================================
  // Control register: overflow-reset enable, default on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stack_overflow_reset_enable_reg <= CTRL_RESET[0];
    end else if (hit(ADDR_CTRL)) begin
      stack_overflow_reset_enable_reg <= wb[0];
    end
  end

  //==========================================================
  // Program counter and latches
  logic branch;
  assign branch = exec && (cmd.op == RSFC_OP_CALL || cmd.op == RSFC_OP_GOTO
                           || cmd.op == RSFC_OP_INTVEC || cmd.op == RSFC_OP_RETURN
                           || cmd.op == RSFC_OP_INTERRUPT_RETURN);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_reg <= 21'h000000;
    end else if (srst_reg) begin
      pc_reg <= 21'h000000;
    end else if (branch && is_pop) begin
      pc_reg <= empty_pop ? 21'h000000 : tos;  // [RULE_08] [RULE_02]
    end else if (branch) begin
      pc_reg <= {cmd.target[20:1], 1'b0};  // [RULE_20]
    end else if (hit(ADDR_PC_LOW)) begin
      pc_reg <= {pc_ulatch_reg, pc_hlatch_reg, wb[7:1], 1'b0};  // [RULE_24] [RULE_16]
    end else if (q1) begin
      pc_reg <= pc_reg + 21'h000002;  // [RULE_18]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_hlatch_reg <= 8'h00;
      pc_ulatch_reg <= 5'h00;
    end else begin
      if (hit(ADDR_PC_HLATCH)) begin
        pc_hlatch_reg <= wb;
      end else if (ahb_rd_reg && ahb_addr_reg == ADDR_PC_LOW) begin
        pc_hlatch_reg <= pc_reg[15:8];
      end
      if (hit(ADDR_PC_ULATCH)) begin
        pc_ulatch_reg <= wb[4:0];
      end else if (ahb_rd_reg && ahb_addr_reg == ADDR_PC_LOW) begin
        pc_ulatch_reg <= pc_reg[20:16];
      end
    end
  end

  //==========================================================
  // Fetch pipeline; flush after a taken branch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_reg    <= 16'h0000;
      flush_reg <= 1'b0;
    end else if (q4) begin
      ir_reg    <= (branch || hit(ADDR_PC_LOW)) ? 16'h0000 : fetch_word;  // [RULE_18] [RULE_20]
      flush_reg <= branch;  // [RULE_20]
    end
  end

  assign fetch_addr           = pc_reg;
  assign instruction_register = ir_reg;
  assign program_counter      = pc_reg;
  assign flush                = flush_reg;
  assign operand_read         = q2 && !flush_reg;  // [RULE_19]
  assign dest_write           = q4 && !flush_reg;  // [RULE_19]

  //==========================================================
  // Fast shadow stack, hidden from software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shadow_reg  <= '0;
      restore_reg <= 1'b0;
    end else begin
      if (exec && (cmd.op == RSFC_OP_INTVEC || (cmd.op == RSFC_OP_CALL && cmd.fast))) begin
        shadow_reg <= ctx_live;  // [RULE_14] [RULE_15]
      end
      restore_reg <= is_pop && cmd.fast && cmd.op != RSFC_OP_POP;  // [RULE_15]
    end
  end
  assign ctx_shadow  = shadow_reg;
  assign ctx_restore = restore_reg;

  //==========================================================
  // Table read: one byte per request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      table_byte_pointer_reg <= 21'h000000;
      table_read_latch_reg   <= 8'h00;
    end else begin
      if (hit(ADDR_TBL_PTR)) begin
        table_byte_pointer_reg <= {13'h0000, wb};
      end
      if (exec && cmd.op == RSFC_OP_TBLRD) begin
        table_read_latch_reg <= prog_byte;  // [RULE_21]
      end
    end
  end
  assign prog_byte_addr = table_byte_pointer_reg;

  //==========================================================
  // Read data, registered in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ahb_go && !hwrite) begin
      case (haddr[13:2])
        ADDR_RETURN_STACK_POINTER:    hrdata <= {24'h000000, stack_full_flag_reg,
                                   stack_underflow_flag_reg, 1'b0,
                                   stack_level_reg};  // [RULE_11]
        ADDR_TOP_LOW:   hrdata <= {24'h000000, tos[7:0]};
        ADDR_TOP_HIGH:  hrdata <= {24'h000000, tos[15:8]};
        ADDR_TOP_UPPER: hrdata <= {27'h0000000, tos[20:16]};
        ADDR_PC_LOW:    hrdata <= {24'h000000, pc_reg[7:0]};
        ADDR_PC_HLATCH: hrdata <= {24'h000000, pc_hlatch_reg};
        ADDR_PC_ULATCH: hrdata <= {27'h0000000, pc_ulatch_reg};
        ADDR_TBL_LATCH: hrdata <= {24'h000000, table_read_latch_reg};
        ADDR_CTRL:      hrdata <= {31'h00000000, stack_overflow_reset_enable_reg};
        default:        hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule : rsfc_top
`default_nettype wire

// *** rsfc_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsfc_properties
  import rsfc_pkg::*;
(
  // Clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Core side
  input wire rsfc_cmd_t   cmd,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        flush,
  input wire logic        ctx_restore,
  input wire rsfc_ctx_t   ctx_shadow,
  input wire logic [15:0] fetch_word,
  input wire logic [15:0] instruction_register,
  input wire logic        operand_read,
  input wire logic        dest_write,
  input wire logic        stack_reset_req
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  //==========================================================
  // Helpers: a branch or a low PC write blanks the fetched word
  logic pcl_wr;
  logic br_cmd;
  assign br_cmd = cmd_valid && (cmd.op == RSFC_OP_CALL || cmd.op == RSFC_OP_GOTO
                  || cmd.op == RSFC_OP_INTVEC || cmd.op == RSFC_OP_RETURN
                  || cmd.op == RSFC_OP_INTERRUPT_RETURN);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pcl_wr <= 1'b0;
    end else begin
      pcl_wr <= hsel && hready && htrans[1] && hwrite && haddr[13:2] == ADDR_PC_LOW;
    end
  end
  //==========================================================
  // Properties
  property p_bus_ok; hreadyout && !hresp; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus stall or error");
  property p_hi_zero; hrdata[31:8] == 24'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("read upper bits set");
  property p_rst_pulse; stack_reset_req |=> !stack_reset_req; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
  property p_quad; cmd_ready |=> !cmd_ready [*3]; endproperty
  a_quad: assert property (p_quad) else $error("phase four too soon");
  property p_write_q4; dest_write |-> cmd_ready; endproperty
  a_write_q4: assert property (p_write_q4) else $error("write off phase four");
  property p_read_q2; operand_read |-> ##2 cmd_ready; endproperty
  a_read_q2: assert property (p_read_q2) else $error("read off phase two");
  // Stack reset holds the phase at Q1 one extra clock and stretches a flush, so it is excused
  property p_flush;
    disable iff (!hresetn || stack_reset_req) $rose(flush) |-> flush [*4] ##1 !flush;
  endproperty
  a_flush: assert property (p_flush) else $error("flush not one cycle");
  property p_ir;
    disable iff (!hresetn || stack_reset_req)
    cmd_ready && !flush && !br_cmd && !pcl_wr |=> instruction_register == $past(fetch_word);
  endproperty
  a_ir: assert property (p_ir) else $error("word not latched");
  property p_ir_flush;
    cmd_ready && !flush && br_cmd |=> instruction_register == 16'h0000 && flush;
  endproperty
  a_ir_flush: assert property (p_ir_flush) else $error("branch word not flushed");
  property p_restore;
    ctx_restore |-> $past(cmd_valid && cmd_ready && !flush && cmd.fast
      && (cmd.op == RSFC_OP_RETURN || cmd.op == RSFC_OP_INTERRUPT_RETURN));
  endproperty
  a_restore: assert property (p_restore) else $error("stray restore");
  property p_shadow; !$stable(ctx_shadow) |-> $past(cmd_valid && cmd_ready); endproperty
  a_shadow: assert property (p_shadow) else $error("shadow moved alone");
endmodule : rsfc_properties
`default_nettype wire

// *** rsfc_decoder_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsfc_decoder_model
  import rsfc_pkg::*;
(
  // Clock
  input  wire logic        hclk,
  // From the block
  input  wire logic        cmd_ready,
  input  wire logic        flush,
  input  wire logic [20:0] fetch_addr,
  input  wire logic [20:0] prog_byte_addr,
  input  wire logic [20:0] program_counter,
  // To the block
  output var rsfc_cmd_t    cmd,
  output logic             cmd_valid,
  output var rsfc_ctx_t    ctx_live,
  output logic [15:0]      fetch_word,
  output logic [7:0]       prog_byte
);
  rsfc_ctx_t   ctx_taken;
  logic [20:0] pc_taken;
  initial begin
    cmd = '0;
    cmd_valid = 1'b0;
    ctx_live = 24'h5A3C96;
  end
  //==========================================================
  // Live context moves every clock so a late capture shows
  always @(posedge hclk) ctx_live <= ctx_live + 24'h010307;
  assign fetch_word = ~fetch_addr[16:1];
  assign prog_byte  = prog_byte_addr[7:0] ^ 8'h3C;
  //==========================================================
  // Command handshake, target even while valid, then inverted
  task automatic send(input rsfc_op_t op, input logic fast, input logic [20:0] tgt);
    @(posedge hclk);
    cmd       <= '{op, fast, {tgt[20:1], 1'b0}};
    cmd_valid <= 1'b1;
    do @(posedge hclk); while (!(cmd_ready === 1'b1 && flush === 1'b0));
    ctx_taken = ctx_live;
    pc_taken  = program_counter;
    cmd_valid <= 1'b0;
    cmd.target <= ~cmd.target;
  endtask : send
endmodule : rsfc_decoder_model
`default_nettype wire

// *** rsfc_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsfc_tb
  import rsfc_pkg::*;
;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        por_n   = 1'b1;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, flush, cmd_ready, cmd_valid, ctx_restore;
  logic        operand_read, dest_write, stack_reset_req;
  logic [20:0] fetch_addr, prog_byte_addr, program_counter, saved;
  logic [15:0] fetch_word, instruction_register;
  logic [7:0]  prog_byte;
  rsfc_cmd_t   cmd;
  rsfc_ctx_t   ctx_live, ctx_shadow;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          resets_seen = 0;

  rsfc_top i_dut (
    .hclk, .hresetn, .por_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cmd, .cmd_valid, .ctx_live,
    .fetch_addr, .fetch_word, .prog_byte_addr, .prog_byte, .instruction_register,
    .program_counter, .flush, .cmd_ready, .ctx_restore, .ctx_shadow, .operand_read,
    .dest_write, .stack_reset_req
  );
  rsfc_decoder_model i_dec (
    .hclk, .cmd_ready, .flush, .fetch_addr, .prog_byte_addr, .program_counter,
    .cmd, .cmd_valid, .ctx_live, .fetch_word, .prog_byte
  );

  always #10 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (stack_reset_req === 1'b1) resets_seen = resets_seen + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end
  //==========================================================
  // Bus and check tasks
  function automatic logic [31:0] ba(input logic [11:0] idx);
    return {18'h0, idx, 2'b00};
  endfunction : ba
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hwrite <= w;
    haddr  <= a;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    bus(1'b1, ba(idx), d);
  endtask : wr
  task automatic rdc(input string nm, input logic [11:0] idx, input logic [31:0] exp);
    bus(1'b0, ba(idx), 32'h0);
    chk(nm, rd, exp);
  endtask : rdc
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  //==========================================================
  // Tests
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("ptr", ADDR_RETURN_STACK_POINTER, 32'h00);
    rdc("ctrl", ADDR_CTRL, 32'h01);
    rdc("unmapped", 12'h040, 32'h00);
    wr(ADDR_RETURN_STACK_POINTER, 32'hFF);
    rdc("ptr", ADDR_RETURN_STACK_POINTER, 32'h1F);
    wr(ADDR_RETURN_STACK_POINTER, 32'h05);
    rdc("ptr", ADDR_RETURN_STACK_POINTER, 32'h05);
    $display("test register access done");
    i_dec.send(RSFC_OP_PUSH, 1'b0, 21'h0);
    rdc("ptr", ADDR_RETURN_STACK_POINTER, 32'h06);
    rdc("top low", ADDR_TOP_LOW, {24'h0, i_dec.pc_taken[7:0]});
    rdc("top high", ADDR_TOP_HIGH, {24'h0, i_dec.pc_taken[15:8]});
    i_dec.send(RSFC_OP_POP, 1'b0, 21'h0);
    rdc("ptr", ADDR_RETURN_STACK_POINTER, 32'h05);
    i_dec.send(RSFC_OP_CALL, 1'b1, 21'h000400);
    rdc("ptr", ADDR_RETURN_STACK_POINTER, 32'h06);
    chk("shadow", {8'h0, ctx_shadow}, {8'h0, i_dec.ctx_taken});
    i_dec.send(RSFC_OP_RETURN, 1'b1, 21'h0);
    rdc("ptr", ADDR_RETURN_STACK_POINTER, 32'h05);
    i_dec.send(RSFC_OP_INTVEC, 1'b0, 21'h000008);
    repeat (2) @(posedge hclk);
    chk("shadow", {8'h0, ctx_shadow}, {8'h0, i_dec.ctx_taken});
    i_dec.send(RSFC_OP_INTERRUPT_RETURN, 1'b1, 21'h0);
    i_dec.send(RSFC_OP_NOP, 1'b0, 21'h0);
    i_dec.send(RSFC_OP_GOTO, 1'b0, 21'h000800);
    $display("test push and pop done");
    // Enable off: faults only flag, no reset
    wr(ADDR_CTRL, 32'h00);
    wr(ADDR_RETURN_STACK_POINTER, 32'h00);
    i_dec.send(RSFC_OP_RETURN, 1'b0, 21'h0);
    rdc("ptr", ADDR_RETURN_STACK_POINTER, 32'h40);
    wr(ADDR_RETURN_STACK_POINTER, 32'hC3);
    rdc("ptr", ADDR_RETURN_STACK_POINTER, 32'h43);
    wr(ADDR_RETURN_STACK_POINTER, 32'h1E);
    i_dec.send(RSFC_OP_CALL, 1'b0, 21'h000200);
    saved = i_dec.pc_taken;
    rdc("ptr", ADDR_RETURN_STACK_POINTER, 32'h9F);
    i_dec.send(RSFC_OP_CALL, 1'b0, 21'h000300);
    rdc("ptr", ADDR_RETURN_STACK_POINTER, 32'h9F);
    rdc("top low", ADDR_TOP_LOW, {24'h0, saved[7:0]});
    chk("resets", resets_seen, 32'h0);
    $display("test faults without reset done");
    wr(ADDR_CTRL, 32'h01);
    wr(ADDR_RETURN_STACK_POINTER, 32'h1E);
    i_dec.send(RSFC_OP_CALL, 1'b0, 21'h000300);
    repeat (4) @(posedge hclk);
    chk("resets", resets_seen, 32'h1);
    rdc("ptr", ADDR_RETURN_STACK_POINTER, 32'h80);
    wr(ADDR_RETURN_STACK_POINTER, 32'h00);
    i_dec.send(RSFC_OP_RETURN, 1'b0, 21'h0);
    repeat (4) @(posedge hclk);
    chk("resets", resets_seen, 32'h2);
    por_n <= 1'b0;
    repeat (4) @(posedge hclk);
    por_n <= 1'b1;
    repeat (3) @(posedge hclk);
    rdc("ptr", ADDR_RETURN_STACK_POINTER, 32'h00);
    $display("test faults with reset done");
    wr(ADDR_TBL_PTR, 32'h5A);
    i_dec.send(RSFC_OP_TBLRD, 1'b0, 21'h0);
    rdc("table", ADDR_TBL_LATCH, {24'h0, 8'h5A ^ 8'h3C});
    wr(ADDR_PC_HLATCH, 32'h12);
    wr(ADDR_PC_ULATCH, 32'h03);
    wr(ADDR_PC_LOW, 32'h40);
    @(posedge hclk);
    chk("pc upper", {19'h0, program_counter[20:8]}, 32'h312);
    $display("test table and program counter done");
    end_sim();
  end
endmodule : rsfc_tb

bind rsfc_top rsfc_properties i_chk (
  .hclk, .hresetn, .hsel, .hready, .haddr, .htrans, .hwrite,
  .hrdata, .hreadyout, .hresp, .cmd, .cmd_valid, .cmd_ready, .flush,
  .ctx_restore, .ctx_shadow, .fetch_word, .instruction_register, .operand_read,
  .dest_write, .stack_reset_req
);
`default_nettype wire
